// File: logic/guard_pkg.sv
// constants shared by the timeout guard and its tick generator
// assumes an 8-bit register port with a 3-bit byte offset
`default_nettype none
package guard_pkg;
  // register byte offsets
  localparam logic [2:0] OFS_CTRL_A   = 3'h0;
  localparam logic [2:0] OFS_CTRL_B   = 3'h1;
  localparam logic [2:0] OFS_CNT_HI   = 3'h2;
  localparam logic [2:0] OFS_CNT_LO   = 3'h3;
  localparam logic [2:0] OFS_LIMIT_HI = 3'h4;
  localparam logic [2:0] OFS_LIMIT_LO = 3'h5;
  localparam logic [2:0] OFS_EARLY_HI = 3'h6;
  localparam logic [2:0] OFS_EARLY_LO = 3'h7;
  // control a field positions
  localparam int A_ENABLE = 7;
  localparam int A_IRQ_EN = 6;
  localparam int A_UPDATE = 5;
  localparam int A_TEST_HI = 4;
  localparam int A_TEST_LO = 3;
  localparam int A_HALT_RUN = 2;
  localparam int A_WAIT_RUN = 1;
  localparam int A_STOP_RUN = 0;
  // control b field positions
  localparam int B_EARLY_CHECK = 7;
  localparam int B_IRQ_PENDING = 6;
  localparam int B_DIV256 = 4;
  localparam int B_SRC_HI = 1;
  localparam int B_SRC_LO = 0;
  // reset values
  localparam logic [7:0]  CTRL_A_RESET = 8'h80;
  localparam logic [7:0]  CTRL_B_RESET = 8'h01;
  localparam logic [15:0] LIMIT_RESET  = 16'h0004;
  localparam logic [15:0] EARLY_RESET  = 16'h0000;
  // fast check encodings
  localparam logic [1:0] CHECK_OFF  = 2'h0;
  localparam logic [1:0] CHECK_USER = 2'h1;
  localparam logic [1:0] CHECK_LOW  = 2'h2;
  localparam logic [1:0] CHECK_HIGH = 2'h3;
  // counter clock sources
  localparam logic [1:0] SRC_BUS  = 2'h0;
  localparam logic [1:0] SRC_1KHZ = 2'h1;
  localparam logic [1:0] SRC_32KHZ = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;
  // sequence words
  localparam logic [15:0] REFRESH_FIRST = 16'h02A6;
  localparam logic [15:0] REFRESH_SECOND = 16'h80B4;
  localparam logic [15:0] UNLOCK_FIRST  = 16'h20C5;
  localparam logic [15:0] UNLOCK_SECOND = 16'h28D9;
  // timing counts in bus clocks; prescaler last count in reference ticks
  localparam logic [7:0] RESET_DELAY_CLKS = 8'h80;
  localparam logic [7:0] UNLOCK_OPEN_CLKS = 8'h80;
  localparam logic [4:0] SEQ_GAP_CLKS     = 5'h10;
  localparam logic [7:0] PRESCALE_LAST    = 8'hFF;
endpackage : guard_pkg
`default_nettype wire

// File: logic/tick_gen.sv
// counter tick generator: source select and optional divide by 256
// assumes oscillator ticks arrive as one-cycle pulses synchronous to core_clk_i
`default_nettype none
module tick_gen
  import guard_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // control side
  tick_if.gen       tk
);
  logic       src_tick;
  logic [7:0] prescale;

  // pick the reference tick
  always_comb
  begin
    case (tk.src)
      SRC_BUS:   src_tick = 1'b1;
      SRC_1KHZ:  src_tick = tk.slow_tick;
      SRC_32KHZ: src_tick = tk.fast_tick;
      SRC_EXT:   src_tick = tk.ext_tick;
      default:   src_tick = 1'b0;
    endcase
  end

  // divide by 256 prescaler
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      prescale <= 8'h00;
    else if (!tk.run)
      prescale <= 8'h00;
    else if (src_tick)
      prescale <= prescale + 8'h01;
  end

  // counting tick, divided or not
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      tk.tick <= 1'b0;
    else
      tk.tick <= tk.run && src_tick && (!tk.div256 || prescale == PRESCALE_LAST); // R16 R17
  end
endmodule : tick_gen
`default_nettype wire

// File: logic/tick_if.sv
// carrier between the guard control and its tick generator
// assumes one clock domain
`default_nettype none
interface tick_if;
  logic [1:0] src;
  logic       div256;
  logic       run;
  logic       slow_tick;
  logic       fast_tick;
  logic       ext_tick;
  logic       tick;
  modport gen (input src, div256, run, slow_tick, fast_tick, ext_tick, output tick);
  modport ctl (output src, div256, run, slow_tick, fast_tick, ext_tick, input tick);
endinterface : tick_if
`default_nettype wire

// File: logic/timeout_guard.sv
// timeout guard: control/status, counter, refresh and unlock checking
// assumes por_i also raises reset_i; registers reached by a byte-wide port
// Contract
// R1: counter runs only while enable bit 7 of control a is set; write-once.
// R2: with irq enabled, an event raises irq, reset follows 128 clocks after vector fetch.
// R3: with irq disabled, no irq and events reset at once.
// R4: without update permission, configuration is locked after the first setup until reset.
// R5: with update permission, writes accepted for 128 clocks after an unlock.
// R6: two-bit write-once fast check field at bits 4..3.
// R7: fast check field is cleared only by power-on reset.
// R8: low-byte check compares only counter low byte with limit low byte.
// R9: high-byte check compares only counter high byte with limit high byte.
// R10: software writes the user encoding after testing; treated as check off.
// R11: counter runs in halt state only when halt-run bit is set.
// R12: counter runs in wait state only when wait-run bit is set.
// R13: counter runs in stop state only when stop-run bit is set.
// R14: early-refresh check enabled by write-once bit 7 of control b.
// R15: pending flag bit 6 sets on an irq event; writing one clears it.
// R16: write-once bit 4 divides the reference clock by 256.
// R17: write-once source field picks bus, 1 kHz, 32 kHz or external clock.
// R18: reserved bits 5 and 3..2 of control b read zero, writes ignored.
// R19: control a resets to 80h, control b to 01h.
// R20: refresh is 02A6 then 80B4 within 16 clocks, else reset.
// R21: unlock is 20C5 then 28D9 within 16 clocks; other words force reset.
// R22: new configuration applies only once every register is written; here early hi/lo are needed only while the early-refresh check is set.
// R23: write-once fields ignore further writes until reset or unlock.
// R24: irq output follows the pending flag while irq is enabled.
`default_nettype none
module timeout_guard
  import guard_pkg::*;
(
  // clock and resets
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       por_i,
  // register port
  input  wire logic       reg_sel_i,
  input  wire logic       reg_wr_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // chip power states
  input  wire logic       halt_state_i,
  input  wire logic       wait_state_i,
  input  wire logic       stop_state_i,
  // counter clock ticks
  input  wire logic       slow_1khz_osc_i,
  input  wire logic       internal_32khz_osc_i,
  input  wire logic       ext_clk_tick_i,
  // system handshake
  input  wire logic       vec_fetch_i,
  output logic            irq_o,
  output logic            guard_reset_o
);
  import guard_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_REFRESH = 2'b01, SEQ_UNLOCK = 2'b10} seq_t;
  typedef enum logic [1:0] {EV_IDLE = 2'b00, EV_FETCH = 2'b01, EV_DELAY = 2'b10, EV_RESET = 2'b11} ev_t;

  tick_if tk();

  logic [7:0]  ctrl_a;         // shadow, test bits kept in fast_check_mode
  logic [1:0]  fast_check_mode;
  logic        early_refresh_check;
  logic        div256_select;
  logic [1:0]  clk_src;
  logic [15:0] limit;
  logic [15:0] early_limit;
  logic [5:0]  written;        // a, b, limit hi/lo, early hi/lo
  logic [7:0]  act_a;
  logic        act_early;
  logic        act_div;
  logic [1:0]  act_src;
  logic [15:0] act_limit;
  logic [15:0] act_early_limit;
  logic        timeout_irq_pending;
  logic [15:0] count;
  logic [7:0]  hi_latch;
  seq_t        seq;
  logic [4:0]  gap;
  logic        refresh_ok;
  logic        seq_err;
  logic [7:0]  unlock_left;
  ev_t         ev;
  logic [7:0]  delay;
  logic        wr;
  logic        rd;
  logic        word_wr;
  logic [15:0] word;
  logic        unlock_open;
  logic        cfg_ready;
  logic        run_en;
  logic        limit_hit;
  logic        trigger;

  // decoded accesses
  assign wr          = reg_sel_i && reg_wr_i;
  assign rd          = reg_sel_i && !reg_wr_i;
  assign word_wr     = wr && reg_addr_i == OFS_CNT_LO;
  assign word        = {hi_latch, reg_wdata_i};
  assign unlock_open = unlock_left != 8'h00;
  assign cfg_ready   = &written[3:0] && (!early_refresh_check || &written[5:4]); // R22

  // run permission from enable and chip state
  assign run_en = act_a[A_ENABLE]                              // R1
               && !(halt_state_i && !act_a[A_HALT_RUN])        // R11
               && !(wait_state_i && !act_a[A_WAIT_RUN])        // R12
               && !(stop_state_i && !act_a[A_STOP_RUN]);       // R13

  // limit compare by fast check mode
  always_comb
  begin
    case (fast_check_mode)
      CHECK_LOW:  limit_hit = count[7:0] == act_limit[7:0];    // R8
      CHECK_HIGH: limit_hit = count[15:8] == act_limit[15:8];  // R9
      default:    limit_hit = count == act_limit;              // R10
    endcase
  end

  assign trigger = ev == EV_IDLE && ((run_en && limit_hit) || seq_err);

  // tick generator hookup
  assign tk.src       = act_src;
  assign tk.div256    = act_div;
  assign tk.run       = run_en;
  assign tk.slow_tick = slow_1khz_osc_i;
  assign tk.fast_tick = internal_32khz_osc_i;
  assign tk.ext_tick  = ext_clk_tick_i;

  tick_gen u_tick (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .tk         (tk.gen)
  );

  // write-once shadow configuration
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_a              <= CTRL_A_RESET;                      // R19
      early_refresh_check <= CTRL_B_RESET[B_EARLY_CHECK];
      div256_select       <= CTRL_B_RESET[B_DIV256];
      clk_src             <= CTRL_B_RESET[B_SRC_HI:B_SRC_LO];
      limit               <= LIMIT_RESET;
      early_limit         <= EARLY_RESET;
      written             <= 6'h00;
    end
    else
    begin
      if (refresh_ok && unlock_open)
        written <= written;
      if (wr && (unlock_open || !written[0]) && reg_addr_i == OFS_CTRL_A)  // R4 R5 R23
      begin
        ctrl_a     <= reg_wdata_i;
        written[0] <= 1'b1;
      end
      if (wr && (unlock_open || !written[1]) && reg_addr_i == OFS_CTRL_B)  // R23
      begin
        early_refresh_check <= reg_wdata_i[B_EARLY_CHECK];     // R14
        div256_select       <= reg_wdata_i[B_DIV256];          // R16 R18
        clk_src             <= reg_wdata_i[B_SRC_HI:B_SRC_LO]; // R17
        written[1]          <= 1'b1;
      end
      if (wr && (unlock_open || !written[2]) && reg_addr_i == OFS_LIMIT_HI)
      begin
        limit[15:8] <= reg_wdata_i;
        written[2]  <= 1'b1;
      end
      if (wr && (unlock_open || !written[3]) && reg_addr_i == OFS_LIMIT_LO)
      begin
        limit[7:0] <= reg_wdata_i;
        written[3] <= 1'b1;
      end
      if (wr && (unlock_open || !written[4]) && reg_addr_i == OFS_EARLY_HI)
      begin
        early_limit[15:8] <= reg_wdata_i;
        written[4]        <= 1'b1;
      end
      if (wr && (unlock_open || !written[5]) && reg_addr_i == OFS_EARLY_LO)
      begin
        early_limit[7:0] <= reg_wdata_i;
        written[5]       <= 1'b1;
      end
      if (seq == SEQ_UNLOCK && word_wr && word == UNLOCK_SECOND && act_a[A_UPDATE])
        written <= 6'h00;                                      // R5
    end
  end

  // fast check field survives all resets but power-on
  always_ff @(posedge core_clk_i or posedge por_i)
  begin
    if (por_i)
      fast_check_mode <= CHECK_OFF;                            // R7
    else if (wr && (unlock_open || !written[0]) && reg_addr_i == OFS_CTRL_A)
      fast_check_mode <= reg_wdata_i[A_TEST_HI:A_TEST_LO];     // R6
  end

  // active configuration, loaded once control a/b and limit are written, early hi/lo too when its check is set
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      act_a           <= CTRL_A_RESET;
      act_early       <= CTRL_B_RESET[B_EARLY_CHECK];
      act_div         <= CTRL_B_RESET[B_DIV256];
      act_src         <= CTRL_B_RESET[B_SRC_HI:B_SRC_LO];
      act_limit       <= LIMIT_RESET;
      act_early_limit <= EARLY_RESET;
    end
    else if (cfg_ready)                                        // R22
    begin
      act_a           <= ctrl_a;
      act_early       <= early_refresh_check;
      act_div         <= div256_select;
      act_src         <= clk_src;
      act_limit       <= limit;
      act_early_limit <= early_limit;
    end
  end

  // refresh and unlock sequence checker
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      seq        <= SEQ_IDLE;
      gap        <= 5'h00;
      hi_latch   <= 8'h00;
      refresh_ok <= 1'b0;
      seq_err    <= 1'b0;
    end
    else
    begin
      refresh_ok <= 1'b0;
      seq_err    <= 1'b0;
      if (wr && reg_addr_i == OFS_CNT_HI)
        hi_latch <= reg_wdata_i;
      case (seq)
        SEQ_IDLE:
        begin
          gap <= 5'h00;
          if (word_wr && word == REFRESH_FIRST)
            seq <= SEQ_REFRESH;
          else if (word_wr && word == UNLOCK_FIRST)
            seq <= SEQ_UNLOCK;
          else if (word_wr)
            seq_err <= 1'b1;                                   // R21
        end
        SEQ_REFRESH, SEQ_UNLOCK:
        begin
          gap <= gap + 5'h01;
          if (word_wr)
          begin
            seq <= SEQ_IDLE;
            if (seq == SEQ_REFRESH && word == REFRESH_SECOND)
            begin
              refresh_ok <= 1'b1;                              // R20
              seq_err    <= act_early && count < act_early_limit; // R14
            end
            else if (!(seq == SEQ_UNLOCK && word == UNLOCK_SECOND))
              seq_err <= 1'b1;                                 // R21
          end
          else if (gap == SEQ_GAP_CLKS - 5'h01)
          begin
            seq     <= SEQ_IDLE;
            seq_err <= 1'b1;                                   // R20
          end
        end
        default:
          seq <= SEQ_IDLE;
      endcase
    end
  end

  // unlock window countdown
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      unlock_left <= 8'h00;
    else if (seq == SEQ_UNLOCK && word_wr && word == UNLOCK_SECOND && act_a[A_UPDATE])
      unlock_left <= UNLOCK_OPEN_CLKS;                         // R5
    else if (unlock_open)
      unlock_left <= unlock_left - 8'h01;
  end

  // watchdog counter
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      count <= 16'h0000;
    else if (refresh_ok)
      count <= 16'h0000;
    else if (tk.tick)
      count <= count + 16'h0001;                               // R1
  end

  // reset-triggering event sequencer
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ev            <= EV_IDLE;
      delay         <= 8'h00;
      guard_reset_o <= 1'b0;
    end
    else
    begin
      case (ev)
        EV_IDLE:
          if (trigger && act_a[A_IRQ_EN])
            ev <= EV_FETCH;                                    // R2
          else if (trigger)
          begin
            ev            <= EV_RESET;                         // R3
            guard_reset_o <= 1'b1;
          end
        EV_FETCH:
        begin
          delay <= 8'h00;
          if (vec_fetch_i)
            ev <= EV_DELAY;
        end
        EV_DELAY:
        begin
          delay <= delay + 8'h01;
          if (delay == RESET_DELAY_CLKS - 8'h01)
          begin
            ev            <= EV_RESET;                         // R2
            guard_reset_o <= 1'b1;
          end
        end
        EV_RESET:
          guard_reset_o <= 1'b1;
        default:
          ev <= EV_IDLE;
      endcase
    end
  end

  // pending flag, set wins over the write-one clear
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      timeout_irq_pending <= 1'b0;
    else if (trigger && act_a[A_IRQ_EN])
      timeout_irq_pending <= 1'b1;                             // R15
    else if (wr && reg_addr_i == OFS_CTRL_B && reg_wdata_i[B_IRQ_PENDING])
      timeout_irq_pending <= 1'b0;                             // R15
  end

  // interrupt request
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= timeout_irq_pending && act_a[A_IRQ_EN];         // R24 R3
  end

  // registered read data
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (rd)
      case (reg_addr_i)
        OFS_CTRL_A:   reg_rdata_o <= {ctrl_a[7:5], fast_check_mode, ctrl_a[2:0]};
        OFS_CTRL_B:   reg_rdata_o <= {early_refresh_check, timeout_irq_pending, 1'b0,
                                      div256_select, 2'b00, clk_src}; // R18
        OFS_CNT_HI:   reg_rdata_o <= count[15:8];
        OFS_CNT_LO:   reg_rdata_o <= count[7:0];
        OFS_LIMIT_HI: reg_rdata_o <= limit[15:8];
        OFS_LIMIT_LO: reg_rdata_o <= limit[7:0];
        OFS_EARLY_HI: reg_rdata_o <= early_limit[15:8];
        default:      reg_rdata_o <= early_limit[7:0];
      endcase
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_DIRECT_RESET: assert property (trigger && !act_a[A_IRQ_EN] |=> guard_reset_o && !irq_o) // R3
    else $error("immediate reset missing");
  AST_DELAYED_RESET: assert property (ev == EV_FETCH && vec_fetch_i |-> ##128 !guard_reset_o ##1 guard_reset_o) // R2
    else $error("delayed reset not at 128 clocks");
  AST_FLAG_SET: assert property (trigger && act_a[A_IRQ_EN] |=> timeout_irq_pending ##1 irq_o) // R15
    else $error("pending flag or irq not raised");
  AST_FLAG_CLEAR: assert property (wr && reg_addr_i == OFS_CTRL_B && reg_wdata_i[B_IRQ_PENDING] && !trigger
                                   |=> !timeout_irq_pending) // R15
    else $error("pending flag not cleared");
  AST_HIGH_BYTE: assert property (ev == EV_IDLE && run_en && fast_check_mode == CHECK_HIGH
                                  && count[15:8] == act_limit[15:8] |=> ev != EV_IDLE) // R9
    else $error("high byte match missed");
  AST_LOW_BYTE: assert property (ev == EV_IDLE && run_en && fast_check_mode == CHECK_LOW
                                 && count[7:0] == act_limit[7:0] |=> ev != EV_IDLE) // R8
    else $error("low byte match missed");
  AST_HALT_FREEZE: assert property (halt_state_i && !act_a[A_HALT_RUN] |=> !tk.tick) // R11
    else $error("counter ticked in halt state");
  AST_UNLOCK_SPAN: assert property (seq == SEQ_UNLOCK && word_wr && word == UNLOCK_SECOND && act_a[A_UPDATE]
                                    |=> unlock_open ##127 unlock_open ##1 !unlock_open) // R5
    else $error("unlock window not 128 clocks");
  AST_LOCKED: assert property (wr && reg_addr_i == OFS_CTRL_A && written[0] && !unlock_open
                               |=> ctrl_a == $past(ctrl_a)) // R4
    else $error("locked control a changed");
  AST_RESERVED_ZERO: assert property (rd && reg_addr_i == OFS_CTRL_B |=> !reg_rdata_o[5] && reg_rdata_o[3:2] == 2'b00) // R18
    else $error("reserved bits read nonzero");

  COV_IRQ_PATH: cover property (trigger && act_a[A_IRQ_EN]);
  COV_REFRESH:  cover property (refresh_ok);
  COV_UNLOCK:   cover property (unlock_left == UNLOCK_OPEN_CLKS);
endmodule : timeout_guard
`default_nettype wire

// File: verification/timeout_guard_tb.sv
// self-checking bench for the timeout guard control and status block
// assumes guard_pkg and the design files are compiled first
`default_nettype none
module timeout_guard_tb
  import guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        por;
  logic        sel;
  logic        wr;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [2:0]  st;
  logic [2:0]  ticks;
  logic        vec;
  logic        irq;
  logic        grst;
  logic [31:0] seed;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [7:0]  d;
  logic        hit;
  logic [2:0]  m;
  logic [1:0]  src;
  int          bad_count;
  int          samples_checked;
  int          cyc;

  timeout_guard u_timeout_guard (
    .core_clk_i           (clk),
    .reset_i              (rst),
    .por_i                (por),
    .reg_sel_i            (sel),
    .reg_wr_i             (wr),
    .reg_addr_i           (addr),
    .reg_wdata_i          (wdata),
    .reg_rdata_o          (rdata),
    .halt_state_i         (st[2]),
    .wait_state_i         (st[1]),
    .stop_state_i         (st[0]),
    .slow_1khz_osc_i      (ticks[0]),
    .internal_32khz_osc_i (ticks[1]),
    .ext_clk_tick_i       (ticks[2]),
    .vec_fetch_i          (vec),
    .irq_o                (irq),
    .guard_reset_o        (grst)
  );

  // xorshift source for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // control a after a plain reset keeps only the check field
  function automatic logic [7:0] a_kept(input logic [7:0] v);
    return CTRL_A_RESET | (v & 8'h18);
  endfunction : a_kept

  // control b read back: reserved bits and clear-only flag read zero
  function automatic logic [7:0] b_read(input logic [7:0] v);
    return v & 8'h93;
  endfunction : b_read

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8

  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // reset for 20 cycles, power-on reset too when p is set
  task automatic do_reset(input logic p);
    rst = 1'b1;
    por = p;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    por = 1'b0;
  endtask : do_reset

  task automatic wreg(input logic [2:0] ad, input logic [7:0] v);
    sel = 1'b1;
    wr = 1'b1;
    addr = ad;
    wdata = v;
    @(negedge clk);
    sel = 1'b0;
    wr = 1'b0;
    @(negedge clk);
  endtask : wreg

  // full configuration with a limit of 0060h, control a last
  task automatic setup(input logic [7:0] ca, input logic [7:0] cb);
    wreg(OFS_LIMIT_HI, 8'h00);
    wreg(OFS_LIMIT_LO, 8'h60);
    wreg(OFS_CTRL_B, cb);
    wreg(OFS_CTRL_A, ca);
  endtask : setup

  // one counter word, high byte first
  task automatic wword(input logic [15:0] w);
    wreg(OFS_CNT_HI, w[15:8]);
    wreg(OFS_CNT_LO, w[7:0]);
  endtask : wword

  task automatic rreg(input logic [2:0] ad, output logic [7:0] v);
    sel = 1'b1;
    wr = 1'b0;
    addr = ad;
    @(negedge clk);
    sel = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rreg

  // watch for the guard reset over n cycles
  task automatic wait_rst(input int n, output logic h);
    h = 1'b0;
    repeat (n)
    begin
      @(negedge clk);
      if (grst === 1'b1)
        h = 1'b1;
    end
  endtask : wait_rst

  // pulse the tick inputs in mask k every other cycle
  task automatic tick_run(input logic [2:0] k, input int n, output logic h);
    h = 1'b0;
    repeat (n)
    begin
      ticks = k;
      @(negedge clk);
      ticks = 3'h0;
      @(negedge clk);
      if (grst === 1'b1)
        h = 1'b1;
    end
  endtask : tick_run

  // illegal counter word once a full configuration is in place
  task automatic bad_write(input logic [7:0] ctl);
    do_reset(1'b1);
    setup(ctl, CTRL_B_RESET);
    wreg(OFS_CNT_LO, 8'h5A);
  endtask : bad_write

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang limit
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    {sel, wr, addr, wdata, st, ticks, vec} = '0;
    seed = 32'h6186;
    // reset values, write-once and reserved bits, random plus all-ones
    for (int i = 0; i < 6; i++)
    begin
      do_reset(1'b1);
      rreg(OFS_CTRL_A, d);
      cmp8("ctrl_a reset", CTRL_A_RESET, d);
      rreg(OFS_CTRL_B, d);
      cmp8("ctrl_b reset", CTRL_B_RESET, d);
      seed = xs(seed);
      a = (i == 0) ? 8'hFF : seed[7:0];
      b = (i == 0) ? 8'hFF : seed[15:8];
      wreg(OFS_CTRL_A, a);
      wreg(OFS_CTRL_A, ~a);
      wreg(OFS_CTRL_B, b);
      wreg(OFS_CTRL_B, ~b);
      rreg(OFS_CTRL_A, d);
      cmp8("ctrl_a once", a, d);
      rreg(OFS_CTRL_B, d);
      cmp8("ctrl_b once", b_read(b), d);
      do_reset(1'b0);
      rreg(OFS_CTRL_A, d);
      cmp8("ctrl_a check kept", a_kept(a), d);
    end
    // event with interrupt off resets at once
    bad_write(8'h00);
    wait_rst(4, hit);
    cmp8("reset undelayed", 8'h01, {7'h0, hit});
    cmp8("irq when off", 8'h00, {7'h0, irq});
    // event with interrupt on waits for vector fetch plus 128
    bad_write(8'h40);
    wait_rst(40, hit);
    cmp8("reset held", 8'h00, {7'h0, hit});
    cmp8("irq raised", 8'h01, {7'h0, irq});
    rreg(OFS_CTRL_B, d);
    cmp8("pending flag", 8'h41, d);
    vec = 1'b1;
    @(negedge clk);
    vec = 1'b0;
    wait_rst(127, hit);
    cmp8("reset delay", 8'h00, {7'h0, hit});
    wait_rst(1, hit);
    cmp8("reset after delay", 8'h01, {7'h0, hit});
    wreg(OFS_CTRL_B, 8'h40);
    wait_rst(3, hit);
    cmp8("irq released", 8'h00, {7'h0, irq});
    rreg(OFS_CTRL_B, d);
    cmp8("flag cleared", CTRL_B_RESET, d);
    // refresh keeps the count off its limit, unlock reopens the write-once fields
    do_reset(1'b1);
    setup(8'hA0, 8'h00);
    wait_rst(60, hit);
    wword(REFRESH_FIRST);
    wword(REFRESH_SECOND);
    wait_rst(40, hit);
    cmp8("refreshed", 8'h00, {7'h0, hit});
    wword(UNLOCK_FIRST);
    wword(UNLOCK_SECOND);
    setup(8'h20, 8'h00);
    rreg(OFS_CTRL_A, d);
    cmp8("ctrl_a unlocked", 8'h20, d);
    wait_rst(130, hit);
    cmp8("stopped", 8'h00, {7'h0, hit});
    wreg(OFS_CTRL_A, 8'h80);
    rreg(OFS_CTRL_A, d);
    cmp8("ctrl_a relocked", 8'h20, d);
    // sources, enable, chip states and prescaler against a limit of 8
    for (int s = 0; s < 9; s++)
    begin
      src = (s >= 1 && s <= 3) ? s[1:0] : 2'h0;
      st = (s >= 5 && s <= 7) ? (3'b100 >> (s - 5)) : 3'h0;
      m = (src != 2'h0) ? (3'b001 << (src - 2'h1)) : 3'h0;
      do_reset(1'b1);
      wreg(OFS_LIMIT_HI, 8'h00);
      wreg(OFS_LIMIT_LO, 8'h08);
      wreg(OFS_CTRL_B, {3'h0, s == 8, 2'h0, src});
      wreg(OFS_CTRL_A, (s == 4) ? 8'h00 : 8'h80);
      tick_run(~m, 20, hit);
      cmp8("count held", {7'h0, s == 0}, {7'h0, hit});
      st = 3'h0;
      tick_run(m, (s == 8) ? 1100 : 20, hit);
      cmp8("count ran", {7'h0, s != 4}, {7'h0, hit});
    end
    close_out();
  end
endmodule : timeout_guard_tb
`default_nettype wire
